// file: tb/serial_in_parallel_out_latched_shifter_test.sv
// self-checking bench for the latched serial-in parallel-out shifter
module serial_in_parallel_out_latched_shifter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sipo_pkg::*;
  logic clk_sys, rst_n;
  sipo_pins_s pins;
  sipo_out_s outs;
  logic [7:0] sh_m, st_m;
  logic [2:0] r;
  int fails, check_count;
  sipo_ctrl u_ctl (.clk_sys(clk_sys), .pins(pins));
  sipo_shifter u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .outs(outs));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [8:0] seen, input logic [8:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // storage takes the pre-edge shift contents
  function automatic logic [15:0] nxt(input logic [15:0] s, input logic d, sh, st);
    nxt = s;
    if (st && pins.store_clear_n) nxt[7:0] = s[15:8];
    if (sh && pins.shift_clear_n) nxt[15:8] = {s[14:8], d};
  endfunction
  task automatic go(input logic d, input logic sh, input logic st);
    u_ctl.pulse(d, sh, st);
    {sh_m, st_m} = nxt({sh_m, st_m}, d, sh, st);
    cmp({outs.parallel, outs.cascade}, {st_m, sh_m[7]});
  endtask
  task automatic clr(input logic sc, input logic rc);
    u_ctl.clear(sc, rc);
    if (!sc) sh_m = SIPO_CLEAR_VAL;
    if (!rc) st_m = SIPO_CLEAR_VAL;
    cmp({outs.parallel, outs.cascade}, {st_m, sh_m[7]});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    fails = 0;
    check_count = 0;
    sh_m = 8'h00;
    st_m = 8'h00;
    rst_n = 1'b0;
    void'($urandom(93791));
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) go(1'b1, 1'b1, 1'b0);
    go(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 40; i++) begin
      r = 3'($urandom);
      go(r[0], r[1], r[2]);
    end
    clr(1'b0, 1'b1);
    go(1'b1, 1'b1, 1'b1);
    clr(1'b1, 1'b0);
    go(1'b1, 1'b1, 1'b1);
    clr(1'b1, 1'b1);
    go(1'b0, 1'b0, 1'b1);
    close_out();
  end
endmodule

// file: tb/sipo_ctrl.sv
// controller model: drives serial data, both clocks and both clears
module sipo_ctrl (
  // system
  input wire logic clk_sys,
  // pins toward the shifter
  output sipo_pkg::sipo_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import sipo_pkg::*;
  initial pins = 5'h05;
  // one 320 ns link period; data moves only after the clock falls
  task automatic pulse(input logic d, input logic sh, input logic st);
    @(posedge clk_sys);
    #1 pins.serial_in = d;
    repeat (3) @(posedge clk_sys);
    // tied clocks rise in one step
    #1 {pins.shift_clock, pins.store_clock} = {sh, st};
    repeat (4) @(posedge clk_sys);
    #1 {pins.shift_clock, pins.store_clock} = 2'h0;
    pins.serial_in = ~d;
  endtask
  task automatic clear(input logic sc, input logic rc);
    @(posedge clk_sys);
    #1 {pins.shift_clear_n, pins.store_clear_n} = {sc, rc};
    repeat (4) @(posedge clk_sys);
    // let the launching edge settle before the bench looks
    #1;
  endtask
endmodule

// file: verilog/sipo_pkg.sv
// package: constants and carrier types for the latched serial-in parallel-out shifter
package sipo_pkg;
  localparam int SIPO_WIDTH = 8;
  localparam logic [SIPO_WIDTH-1:0] SIPO_CLEAR_VAL = 8'h00;
  localparam int SIPO_LAST_STAGE = SIPO_WIDTH - 1;
  localparam int SIPO_FIRST_STAGE = 0;
  localparam logic [1:0] SIPO_EDGE_RISE = 2'h1;
  localparam logic [1:0] SIPO_EDGE_FALL = 2'h2;

  // pin bundle from the external controller
  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic shift_clear_n;
    logic store_clock;
    logic store_clear_n;
  } sipo_pins_s;

  // outputs: parallel a..h in bits 0..7, plus cascade
  typedef struct packed {
    logic [SIPO_WIDTH-1:0] parallel;
    logic cascade;
  } sipo_out_s;
endpackage

// file: verilog/sipo_shifter.sv
// module: sampled serial-in parallel-out shifter with storage register and cascade
import sipo_pkg::*;

// How it works
// - eight shift stages transfer into a separate eight-bit storage register
// - each register has own clock and clear; clear overrides clock
// - shift clear low forces all shift stages to zero
// - rising shift clock loads serial input into the first stage
// - same edge moves every later stage from its predecessor
// - falling shift clock leaves shift stages unchanged
// - store clear low forces storage bits and parallel outputs to zero
// - rising store clock captures all eight shift stages in parallel
// - falling store clock leaves storage contents unchanged
// - both clocks act on rising edges only
// - tied clocks capture pre-edge shift contents, lagging by one pulse
// - cascade output follows last stage and clears with shift clear
module sipo_shifter (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // controller pins
  input wire sipo_pkg::sipo_pins_s pins,
  // outputs
  output sipo_pkg::sipo_out_s outs
);
  import sipo_pkg::*;

  // two-flop synchronisers; stage one is read only by stage two
  sipo_pins_s sync1_reg;
  sipo_pins_s sync2_reg;
  logic shclk_prev_reg;
  logic stclk_prev_reg;
  logic [SIPO_WIDTH-1:0] shift_reg;
  logic [SIPO_WIDTH-1:0] shift_next;
  logic [SIPO_WIDTH-1:0] store_reg;
  logic [SIPO_WIDTH-1:0] store_next;
  logic cascade_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shclk_prev_reg <= 1'b0;
      stclk_prev_reg <= 1'b0;
    end else begin
      shclk_prev_reg <= sync2_reg.shift_clock;
      stclk_prev_reg <= sync2_reg.store_clock;
    end
  end

  // edge detection on the sampled clocks
  wire [1:0] shclk_hist = {shclk_prev_reg, sync2_reg.shift_clock};
  wire [1:0] stclk_hist = {stclk_prev_reg, sync2_reg.store_clock};
  wire shift_rise = (shclk_hist == SIPO_EDGE_RISE);
  wire store_rise = (stclk_hist == SIPO_EDGE_RISE);
  wire shift_clr = !sync2_reg.shift_clear_n;
  wire store_clr = !sync2_reg.store_clear_n;
  // falling edges, read only by the hold checks
  wire shift_fall = (shclk_hist == SIPO_EDGE_FALL);
  wire store_fall = (stclk_hist == SIPO_EDGE_FALL);

  wire [SIPO_WIDTH-1:0] shifted;
  assign shifted[SIPO_FIRST_STAGE] = sync2_reg.serial_in;
  genvar gi;
  generate
    for (gi = 1; gi < SIPO_WIDTH; gi++) begin : g_stage
      assign shifted[gi] = shift_reg[gi-1];
    end
  endgenerate

  // clear has priority over the clock; shift clear wins; hold otherwise
  assign shift_next = shift_clr ? SIPO_CLEAR_VAL : (shift_rise ? shifted : shift_reg);
  // capture uses shift_reg as it stood before this edge, so lag holds
  assign store_next = store_clr ? SIPO_CLEAR_VAL : (store_rise ? shift_reg : store_reg);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shift_reg <= SIPO_CLEAR_VAL;
      store_reg <= SIPO_CLEAR_VAL;
      cascade_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      store_reg <= store_next;
      cascade_reg <= shift_next[SIPO_LAST_STAGE];
    end
  end

  // bit 0 is output a; one driver for the whole bundle
  assign outs = {store_reg, cascade_reg};

  // assertions; registers move on the edge, so most checks look one cycle later

  sequence s_shift_step;
    shift_rise && !shift_clr;
  endsequence

  sequence s_store_step;
    store_rise && !store_clr;
  endsequence

  sequence s_shift_idle;
    !shift_rise && !shift_clr;
  endsequence

  sequence s_store_idle;
    !store_rise && !store_clr;
  endsequence

  sequence s_shift_fall_step;
    shift_fall && !shift_clr;
  endsequence

  sequence s_store_fall_step;
    store_fall && !store_clr;
  endsequence

  sequence s_tied_step;
    shift_rise && store_rise && !shift_clr && !store_clr;
  endsequence

  // shift clear lifts, no edge pending
  sequence s_shift_clear_end;
    shift_clr ##1 (!shift_clr && !shift_rise);
  endsequence

  // store clear lifts, no edge pending
  sequence s_store_clear_end;
    store_clr ##1 (!store_clr && !store_rise);
  endsequence

  sequence s_shift_pin_rise;
    !sync2_reg.shift_clock ##1 sync2_reg.shift_clock;
  endsequence

  sequence s_store_pin_rise;
    !sync2_reg.store_clock ##1 sync2_reg.store_clock;
  endsequence

  sequence s_clear_beats_shift;
    shift_clr && shift_rise;
  endsequence

  sequence s_clear_beats_store;
    store_clr && store_rise;
  endsequence

  a_shift_clear_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shift_clr |=> (shift_reg == SIPO_CLEAR_VAL))
    else $error("shift stages not cleared");

  a_first_stage_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_step |=> shift_reg[SIPO_FIRST_STAGE] == $past(sync2_reg.serial_in))
    else $error("first stage missed serial input");

  a_stage_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_step |=> shift_reg[SIPO_LAST_STAGE:SIPO_FIRST_STAGE+1] ==
      $past(shift_reg[SIPO_LAST_STAGE-1:SIPO_FIRST_STAGE]))
    else $error("stages did not advance");

  a_shift_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_idle |=> $stable(shift_reg))
    else $error("shift changed without rising edge");

  a_store_clear_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    store_clr |=> (outs.parallel == SIPO_CLEAR_VAL))
    else $error("storage not cleared");

  a_store_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_store_step |=> outs.parallel == $past(shift_reg))
    else $error("storage missed shift contents");

  a_store_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_store_idle |=> $stable(store_reg))
    else $error("storage changed without rising edge");

  a_cascade_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    outs.cascade == shift_reg[SIPO_LAST_STAGE])
    else $error("cascade differs from last stage");

  a_shift_fall_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_fall_step |=> $stable(shift_reg))
    else $error("shift moved on a falling edge");

  a_store_fall_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_store_fall_step |=> $stable(store_reg))
    else $error("storage moved on a falling edge");

  a_shift_edge_seen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_pin_rise |-> shift_rise)
    else $error("shift clock rise not detected");

  a_store_edge_seen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_store_pin_rise |-> store_rise)
    else $error("store clock rise not detected");

  a_shift_edge_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shift_rise |=> !shift_rise)
    else $error("shift edge seen twice");

  a_store_edge_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    store_rise |=> !store_rise)
    else $error("store edge seen twice");

  a_shift_clear_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_clear_beats_shift |=> shift_reg == SIPO_CLEAR_VAL)
    else $error("shift edge overrode the clear");

  a_store_clear_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_clear_beats_store |=> outs.parallel == SIPO_CLEAR_VAL)
    else $error("store edge overrode the clear");

  a_shift_clear_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_clear_end |=> shift_reg == SIPO_CLEAR_VAL)
    else $error("shift stages left zero without an edge");

  a_store_clear_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_store_clear_end |=> outs.parallel == SIPO_CLEAR_VAL)
    else $error("storage left zero without an edge");

  a_tied_lag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_tied_step |=> (outs.parallel == $past(shift_reg)) && (shift_reg == $past(shifted)))
    else $error("tied clocks did not give a one pulse lag");

  a_cascade_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_step |=> outs.cascade == $past(shift_reg[SIPO_LAST_STAGE-1]))
    else $error("cascade missed the shifted stage");

  a_cascade_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shift_clr |=> !outs.cascade)
    else $error("cascade not cleared");

  a_cascade_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_shift_idle |=> $stable(outs.cascade))
    else $error("cascade changed without a shift edge");

  a_shift_ignores_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (store_clr && shift_rise && !shift_clr) |=> shift_reg == $past(shifted))
    else $error("store clear blocked the shift");

  a_store_ignores_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (shift_clr && store_rise && !store_clr) |=> outs.parallel == $past(shift_reg))
    else $error("shift clear blocked the capture");

  a_store_stays_put: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (shift_rise && !store_rise && !store_clr) |=> $stable(store_reg))
    else $error("storage followed the shift register");

  a_parallel_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_store_idle |=> $stable(outs.parallel))
    else $error("outputs changed without a store edge");

  // each output carries its own stage
  generate
    for (gi = 0; gi < SIPO_WIDTH; gi++) begin : g_out_map
      a_out_bit_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_store_step |=> outs.parallel[gi] == $past(shift_reg[gi]))
        else $error("output bit differs from its stage");
    end
  endgenerate
endmodule
